// *** hw/alu_exec_defines.vh ***
// Constants for the logic and arithmetic execution unit
`ifndef ALU_EXEC_DEFINES_VH
`define ALU_EXEC_DEFINES_VH

// Register offsets (word index; byte address = index * 4)
`define REG_OPCODE      4'h0
`define REG_ACC         4'h1
`define REG_STATUS      4'h2
`define REG_MULTIPLY_HIGH_REGISTER        4'h3
`define REG_EXEC        4'h4
`define REG_RESULT      4'h5
`define REG_WDOG        4'h6
`define REG_FILEDATA    4'h7
`define REG_FILEADDR    4'h8

// Status register bit positions
`define ST_CARRY        0
`define ST_DCARRY       1
`define ST_ZERO         2

// Result register bit positions
`define RS_SKIP         0
`define RS_FWRITE       1
`define RS_DONE         2
`define RS_CYCLES_LO    8

// Reset values
`define ACC_RST         8'h00
`define STATUS_RST      8'h00
`define MULTIPLY_HIGH_REGISTER_RST        8'h00

// Opcode field positions
`define FADDR_MSB       8
`define DEST_BIT        9
`define LIT_MSB         7

// Watchdog width and file register depth
`define WDOG_W          16
`define FILE_DEPTH      512

`endif

// *** hw/file_ram.v ***
// File register memory with registered read data
`timescale 1ns/1ps
module file_ram #(
  parameter AW = 9,
  parameter DW = 8
) (
  input  wire          clk_sys,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // file_ram

// *** hw/logic_arith_exec_unit.v ***
// Logic, arithmetic, skip and multiply execution unit with Avalon-MM access
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "alu_exec_defines.vh"
module logic_arith_exec_unit #(
  parameter WDOG_PRESCALE = 8
) (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg         skipRequest,
  output reg         watchdogExpired
);
  localparam S_IDLE = 4'b0001;
  localparam S_READ = 4'b0010;
  localparam S_EXEC = 4'b0100;
  localparam S_SKIP = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Low-nibble and full 8-bit add with carry in: {c8, c4, sum}
  function [9:0] addFlags;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [8:0] full;
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      addFlags = {full[8], lo[4], full[7:0]};
    end
  endfunction

  function [7:0] mergeByte;
    input [7:0] old;
    input [7:0] data;
    input       en;
    begin
      mergeByte = en ? data : old;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [15:0] opcode_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  status_r;
  reg  [7:0]  mulHigh_r;
  reg         skip_r;
  reg         fileWr_r;
  reg         done_r;
  reg  [1:0]  cycles_r;
  reg  [1:0]  skipCnt_r;
  reg  [15:0] wdog_r;
  reg  [7:0]  prescale_r;
  reg  [8:0]  hostAddr_r;
  reg         hostWr_r;
  reg  [7:0]  hostData_r;
  wire [7:0]  ramRdData;

  wire [15:0] busAddrIdx = {10'h000, address};
  wire [8:0]  fileAddr   = opcode_r[`FADDR_MSB:0];
  wire        toFile     = opcode_r[`DEST_BIT];
  wire        isLiteral  = (opcode_r[15:12] == 4'h7);
  wire [7:0]  literal    = opcode_r[`LIT_MSB:0];
  wire        carryIn    = status_r[`ST_CARRY];

  ////////////////////////////////////////////////////////////////////////////
  // Execute datapath

  reg  [7:0]  operand;
  reg  [7:0]  result;
  reg  [9:0]  arith;
  reg         wrAcc;
  reg         wrFile;
  reg         updZ;
  reg         updCarries;
  reg         updC;
  reg         newC;
  reg         skipTaken;
  reg         wrMul;
  reg         wdClear;
  reg  [15:0] product;

  always @* begin
    operand    = isLiteral ? literal : ramRdData;
    result     = 8'h00;
    arith      = 10'h000;
    wrAcc      = 1'b0;
    wrFile     = 1'b0;
    updZ       = 1'b0;
    updCarries = 1'b0;
    updC       = 1'b0;
    newC       = 1'b0;
    skipTaken  = 1'b0;
    wrMul      = 1'b0;
    wdClear    = 1'b0;
    product    = 16'h0000;
    if (isLiteral) begin
      wrAcc = 1'b1;
      case (opcode_r[11:8])
        4'he: begin result = acc_r & operand; updZ = 1'b1; end
        4'hd: begin result = acc_r | operand; updZ = 1'b1; end
        4'hf: begin result = acc_r ^ operand; updZ = 1'b1; end
        4'hb: begin
          arith = addFlags(acc_r, operand, 1'b0);
          result = arith[7:0];
          updZ = 1'b1;
          updCarries = 1'b1;
        end
        4'ha, 4'h9: begin
          arith = addFlags(operand, ~acc_r, 1'b1);
          result = arith[7:0];
          updZ = 1'b1;
          updCarries = 1'b1;
          wrAcc = (opcode_r[11:8] == 4'ha);
        end
        4'h7: begin wrAcc = 1'b0; skipTaken = (operand == acc_r); end
        4'h6: begin wrAcc = 1'b0; skipTaken = (operand != acc_r); end
        4'h2: begin
          product = operand * acc_r;
          result = product[7:0];
          wrMul = 1'b1;
        end
        4'h3: begin
          product = $signed(operand) * $signed(acc_r);
          result = product[7:0];
          wrMul = 1'b1;
        end
        default: wrAcc = 1'b0;
      endcase
    end else if (opcode_r == 16'h0004) begin
      wdClear = 1'b1;
    end else begin
      wrAcc  = ~toFile;
      wrFile = toFile;
      case (opcode_r[15:10])
        6'h05: begin result = acc_r & operand; updZ = 1'b1; end
        6'h04: begin result = acc_r | operand; updZ = 1'b1; end
        6'h06: begin result = acc_r ^ operand; updZ = 1'b1; end
        6'h09: begin result = ~operand; updZ = 1'b1; end
        6'h07, 6'h17: begin
          arith = addFlags(acc_r, operand,
                           (opcode_r[14] & carryIn));
          result = arith[7:0];
          updZ = 1'b1;
          updCarries = 1'b1;
        end
        6'h02, 6'h12: begin
          arith = addFlags(operand, ~acc_r,
                           opcode_r[14] ? carryIn : 1'b1);
          result = arith[7:0];
          updZ = 1'b1;
          updCarries = 1'b1;
        end
        6'h01: begin
          // Destination bit set does nothing: no compare, no write, no flag update
          if (!toFile) begin
            arith = addFlags(operand, ~acc_r, 1'b1);
            result = arith[7:0];
            updZ = 1'b1;
            updCarries = 1'b1;
          end
          wrAcc = 1'b0;
          wrFile = 1'b0;
        end
        6'h10: begin
          // Equal and not-equal skips share the field, bit 9 picks
          wrAcc = 1'b0;
          wrFile = 1'b0;
          skipTaken = toFile ? (operand == acc_r) : (operand != acc_r);
        end
        6'h03, 6'h0a: begin
          result = opcode_r[13] ? operand + 8'h01 : operand - 8'h01;
          updZ = 1'b1;
        end
        6'h0b: begin result = operand - 8'h01; skipTaken = (result == 8'h00); end
        6'h13: begin result = operand - 8'h01; skipTaken = (result != 8'h00); end
        6'h0f: begin result = operand + 8'h01; skipTaken = (result == 8'h00); end
        6'h16: begin result = operand + 8'h01; skipTaken = (result != 8'h00); end
        6'h08: begin
          wrAcc = 1'b0;
          wrFile = 1'b0;
          updZ = toFile;
          result = operand;
        end
        6'h14: begin
          wrAcc = 1'b1;
          wrFile = 1'b0;
          product = operand * acc_r;
          result = product[7:0];
          wrMul = 1'b1;
        end
        6'h15: begin
          wrAcc = 1'b1;
          wrFile = 1'b0;
          product = $signed(operand) * $signed(acc_r);
          result = product[7:0];
          wrMul = 1'b1;
        end
        6'h0d: begin
          result = {operand[6:0], carryIn};
          updC = 1'b1;
          newC = operand[7];
        end
        6'h0c: begin
          result = {carryIn, operand[7:1]};
          updC = 1'b1;
          newC = operand[0];
        end
        6'h0e: result = {operand[3:0], operand[7:4]};
        default: begin
          wrAcc = 1'b0;
          wrFile = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @* begin
    case (state_r)
      // Held request after its ack must not launch again
      S_IDLE: state_nxt = (write && waitrequest && busAddrIdx == {12'h000, `REG_EXEC})
                          ? S_READ : S_IDLE;
      S_READ: state_nxt = S_EXEC;
      S_EXEC: state_nxt = skipTaken ? S_SKIP : S_IDLE;
      S_SKIP: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  wire execNow = (state_r == S_EXEC);

  file_ram #(
    .AW (9),
    .DW (8)
  ) u_file_ram (
    .clk_sys (clk_sys),
    .wrEn    (execNow ? wrFile : hostWr_r),
    .wrAddr  (execNow ? fileAddr : hostAddr_r),
    .wrData  (execNow ? result : hostData_r),
    .rdAddr  ((state_r == S_IDLE) ? hostAddr_r : fileAddr),
    .rdData  (ramRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and bus

  wire busWr = write & ~waitrequest;
  // Read data loaded with the ack so it stands while waitrequest is low
  wire busRd = read & waitrequest & (state_r == S_IDLE);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r         <= S_IDLE;
      opcode_r        <= 16'h0000;
      acc_r           <= `ACC_RST;
      status_r        <= `STATUS_RST;
      mulHigh_r       <= `MULTIPLY_HIGH_REGISTER_RST;
      skip_r          <= 1'b0;
      fileWr_r        <= 1'b0;
      done_r          <= 1'b0;
      cycles_r        <= 2'h0;
      skipCnt_r       <= 2'h0;
      wdog_r          <= 16'h0000;
      prescale_r      <= 8'h00;
      hostAddr_r      <= 9'h000;
      hostWr_r        <= 1'b0;
      hostData_r      <= 8'h00;
      readdata        <= 32'h00000000;
      waitrequest     <= 1'b1;
      skipRequest     <= 1'b0;
      watchdogExpired <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      hostWr_r <= 1'b0;
      // Waitrequest drops for one cycle per access while idle
      waitrequest <= ~((read | write) & waitrequest & (state_r == S_IDLE)
                       & (state_nxt == S_IDLE));
      if (state_r == S_READ) begin
        done_r    <= 1'b0;
        cycles_r  <= 2'h0;
        skipCnt_r <= 2'h0;
      end
      if (execNow) begin
        if (wrAcc) acc_r <= result;
        if (wrMul) mulHigh_r <= product[15:8];
        if (updZ) status_r[`ST_ZERO] <= (result == 8'h00);
        if (updCarries) begin
          status_r[`ST_CARRY]  <= arith[9];
          status_r[`ST_DCARRY] <= arith[8];
        end
        if (updC) status_r[`ST_CARRY] <= newC;
        skip_r      <= skipTaken;
        skipRequest <= skipTaken;
        fileWr_r    <= wrFile;
        cycles_r    <= 2'h1;
        done_r      <= ~skipTaken;
        if (!skipTaken) waitrequest <= 1'b0;
      end
      if (state_r == S_SKIP) begin
        cycles_r    <= 2'h2;
        done_r      <= 1'b1;
        skipRequest <= 1'b0;
        waitrequest <= 1'b0;
      end
      // Watchdog counter with prescaler
      if (execNow && wdClear) begin
        wdog_r     <= 16'h0000;
        prescale_r <= 8'h00;
      end else if (prescale_r == WDOG_PRESCALE[7:0] - 8'h01) begin
        prescale_r <= 8'h00;
        if (wdog_r != 16'hffff) wdog_r <= wdog_r + 16'h0001;
        watchdogExpired <= (wdog_r == 16'hfffe);
      end else begin
        prescale_r <= prescale_r + 8'h01;
      end
      if (busWr && state_r == S_IDLE) begin
        case (busAddrIdx[3:0])
          `REG_OPCODE: begin
            if (byteenable[0]) opcode_r[7:0] <= writedata[7:0];
            if (byteenable[1]) opcode_r[15:8] <= writedata[15:8];
          end
          `REG_ACC:    acc_r <= mergeByte(acc_r, writedata[7:0], byteenable[0]);
          `REG_STATUS: status_r <= mergeByte(status_r, writedata[7:0], byteenable[0]);
          `REG_MULTIPLY_HIGH_REGISTER:   mulHigh_r <= mergeByte(mulHigh_r, writedata[7:0], byteenable[0]);
          `REG_FILEADDR: begin
            if (byteenable[0]) hostAddr_r[7:0] <= writedata[7:0];
            if (byteenable[1]) hostAddr_r[8] <= writedata[8];
          end
          `REG_FILEDATA: begin
            hostData_r <= writedata[7:0];
            hostWr_r   <= byteenable[0];
          end
          default: ;
        endcase
      end
      if (busRd) begin
        case (busAddrIdx)
          {12'h000, `REG_OPCODE}:   readdata <= {16'h0000, opcode_r};
          {12'h000, `REG_ACC}:      readdata <= {24'h000000, acc_r};
          {12'h000, `REG_STATUS}:   readdata <= {24'h000000, status_r};
          {12'h000, `REG_MULTIPLY_HIGH_REGISTER}:     readdata <= {24'h000000, mulHigh_r};
          {12'h000, `REG_RESULT}:   readdata <= {22'h000000, cycles_r, 5'h00,
                                                 done_r, fileWr_r, skip_r};
          {12'h000, `REG_WDOG}:     readdata <= {16'h0000, wdog_r};
          {12'h000, `REG_FILEDATA}: readdata <= {24'h000000, ramRdData};
          {12'h000, `REG_FILEADDR}: readdata <= {23'h000000, hostAddr_r};
          default:                  readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // logic_arith_exec_unit

// *** bench/logic_arith_exec_unit_asserts.sv ***
// Port-level assertions for the execution unit
`timescale 1ns/1ps
module exec_unit_checker #(
  parameter WDOG_PRESCALE = 8
) (
  input wire        clk_sys,
  input wire        rst_b,
  input wire [5:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        skipRequest,
  input wire        watchdogExpired
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_ack_plain :
    assert property (($rose(read) || $rose(write)) && !(write && address == 6'h4)
      |=> !waitrequest) else $error("plain access not acked next cycle");
  chk_wait_pulse :
    assert property (!waitrequest |=> waitrequest) else $error("ack longer than one cycle");
  chk_exec_span :
    assert property ($rose(write) && address == 6'h4 |=> waitrequest[*2] ##[1:2] !waitrequest)
      else $error("execution length wrong");
  chk_skip_ack :
    assert property (skipRequest |=> !waitrequest) else $error("taken skip not acked next");
  chk_skip_pulse :
    assert property (skipRequest |=> !skipRequest) else $error("skip pulse too long");
  chk_skip_context :
    assert property (skipRequest |-> write && address == 6'h4 && waitrequest)
      else $error("skip outside execution");
  chk_unmapped_zero :
    assert property (read && !waitrequest && address > 6'h8 |-> readdata == 32'h0)
      else $error("unmapped read not zero");
  chk_rdata_hold :
    assert property (!read |=> $stable(readdata)) else $error("read data moved without read");
  chk_reset_idle :
    assert property ($rose(rst_b) |-> waitrequest && !skipRequest && !watchdogExpired)
      else $error("outputs not idle after reset");
endmodule // exec_unit_checker

bind logic_arith_exec_unit exec_unit_checker #(.WDOG_PRESCALE(WDOG_PRESCALE)) chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .skipRequest(skipRequest), .watchdogExpired(watchdogExpired));

// *** bench/logic_arith_exec_unit_tb.sv ***
// Table-driven testbench for the execution unit
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nMismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module logic_arith_exec_unit_tb;
  typedef struct packed {
    logic [15:0] op;
    logic [7:0]  w, st, f, ew, est, ef, eh;
    logic [3:0]  sk;
  } row_t;
  logic        clk_sys = 1'h0;
  logic        rst_b = 1'h0;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [5:0]  address = 6'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire         skipRequest;
  wire         watchdogExpired;
  logic [31:0] q;
  row_t        r;
  row_t        t [30];
  int          nMismatch = 0;
  int          nTests = 0;
  int          nSkip = 0;
  int          s0;

  logic_arith_exec_unit #(.WDOG_PRESCALE(2)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .skipRequest(skipRequest), .watchdogExpired(watchdogExpired));

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (skipRequest === 1'h1) nSkip <= nSkip + 1;

  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk_sys);
    while (waitrequest !== 1'h0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) begin
      nMismatch++;
      endSim;
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clk_sys);
  endtask

  task endSim;
    $display("Tests %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    nMismatch++;
    endSim;
  end

  ////////////////////////////////////////////////////////////////
  // Fields: opcode, acc, status, file | exp acc, status, file, high byte, skip
  initial begin
    t = '{
      76'h17a5_f0_00_3c_f0_00_30_00_0,
      76'h7e0f_f0_03_3c_00_07_3c_00_0,
      76'h7fff_ff_00_12_00_04_12_00_0,
      76'h27a5_11_01_ff_11_05_00_00_0,
      76'h1da5_88_00_88_10_03_88_00_0,
      76'h7b01_ff_00_44_00_07_44_00_0,
      76'h5fa5_01_01_0e_01_02_10_00_0,
      76'h09a5_01_00_10_0f_01_10_00_0,
      76'h7a05_06_07_33_ff_00_33_00_0,
      76'h4ba5_05_04_05_05_00_ff_00_0,
      76'h4ba5_05_01_05_05_07_00_00_0,
      76'h05a5_42_00_42_42_07_42_00_0,
      76'h7910_20_07_33_20_02_33_00_0,
      76'h43a5_55_03_55_55_03_55_00_1,
      76'h7754_55_00_11_55_00_11_00_0,
      76'h7654_55_00_11_55_00_11_00_1,
      76'h41a5_55_04_55_55_04_55_00_0,
      76'h23a5_9a_00_00_9a_04_00_00_0,
      76'h0da5_77_03_01_00_07_01_00_0,
      76'h2ba5_77_00_ff_77_04_00_00_0,
      76'h2fa5_77_00_01_77_00_00_00_1,
      76'h4da5_77_02_01_00_02_01_00_0,
      76'h4fa5_77_00_05_77_00_04_00_1,
      76'h3da5_77_00_ff_00_00_ff_00_1,
      76'h5ba5_77_00_10_77_00_11_00_1,
      76'h7210_20_00_33_00_00_33_02_0,
      76'h55a5_fe_00_03_fa_00_03_ff_0,
      76'h37a5_77_04_81_77_05_02_00_0,
      76'h39a5_77_07_3c_c3_07_3c_00_0,
      76'h0004_77_07_3c_77_07_3c_00_0
    };
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    for (int a = 1; a < 4; a++) begin
      bus(1'h0, a[5:0], 32'h0);
      `CHK(q[7:0], 8'h00)
    end
    bus(1'h1, 6'h8, 32'h1a5);
    for (int i = 0; i < 30; i++) begin
      r = t[i];
      bus(1'h1, 6'h7, {24'h0, r.f});
      bus(1'h1, 6'h1, {24'h0, r.w});
      bus(1'h1, 6'h2, {24'h0, r.st});
      bus(1'h1, 6'h3, 32'h0);
      bus(1'h1, 6'h0, {16'h0, r.op});
      s0 = nSkip;
      bus(1'h1, 6'h4, 32'h0);
      bus(1'h0, 6'h1, 32'h0);
      `CHK(q[7:0], r.ew)
      bus(1'h0, 6'h2, 32'h0);
      `CHK(q[7:0], r.est)
      bus(1'h0, 6'h3, 32'h0);
      `CHK(q[7:0], r.eh)
      bus(1'h0, 6'h7, 32'h0);
      `CHK(q[7:0], r.ef)
      bus(1'h0, 6'h5, 32'h0);
      `CHK(q[9:8], r.sk[0] ? 2'h2 : 2'h1)
      `CHK(q[0], r.sk[0])
      `CHK(nSkip - s0, int'(r.sk[0]))
    end
    bus(1'h0, 6'h6, 32'h0);
    `CHK(q[15:4], 12'h000)
    `CHK(watchdogExpired, 1'h0)
    bus(1'h1, 6'h3f, 32'hffffffff);
    bus(1'h0, 6'h3f, 32'h0);
    `CHK(q, 32'h0)
    bus(1'h0, 6'h1, 32'h0);
    `CHK(q[7:0], 8'h77)
    rst_b <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    bus(1'h0, 6'h1, 32'h0);
    `CHK(q[7:0], 8'h00)
    endSim;
  end
endmodule // logic_arith_exec_unit_tb
